// ---- aof_host.sv ----
// host processor model on the register port
`timescale 1ns/10ps
module aof_host (
  // clock
  input  wire logic       sys_clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  output logic            reg_rd_last
);
  initial {reg_addr, reg_wr, reg_wdata, reg_rd, reg_rd_last} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge sys_clk);
    {reg_wdata, reg_wr} <= {~d, 1'b0};
  endtask : wr
  // one burst per sample so it cannot change midway outside bypass
  task automatic rd(input logic [7:0] a, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge sys_clk);
      {reg_addr, reg_rd, reg_rd_last} <= {a + 8'(i), 1'b1, i == n - 1};
    end
    @(posedge sys_clk);
    {reg_addr, reg_rd, reg_rd_last} <= {~reg_addr, 2'b00};
  endtask : rd
endmodule : aof_host

// ---- aof_pkg.sv ----
// constants for the accelerometer output buffer
package aof_pkg;
  localparam int unsigned AOF_DEPTH      = 32;
  localparam int unsigned AOF_PTR_W      = 5;
  localparam int unsigned AOF_CNT_W      = 6;
  localparam int unsigned AOF_SMP_W      = 16;
  localparam int unsigned AOF_ENT_W      = 48;
  // register offsets
  localparam logic [7:0] AOF_X_LOW_ADDR  = 8'h32;
  localparam logic [7:0] AOF_X_HIGH_ADDR = 8'h33;
  localparam logic [7:0] AOF_Y_LOW_ADDR  = 8'h34;
  localparam logic [7:0] AOF_Y_HIGH_ADDR = 8'h35;
  localparam logic [7:0] AOF_Z_LOW_ADDR  = 8'h36;
  localparam logic [7:0] AOF_Z_HIGH_ADDR = 8'h37;
  localparam logic [7:0] AOF_CTL_ADDR    = 8'h38;
  localparam logic [7:0] AOF_STAT_ADDR   = 8'h39;
  // buffer_control fields
  localparam int unsigned AOF_MODE_MSB   = 7;
  localparam int unsigned AOF_MODE_LSB   = 6;
  localparam int unsigned AOF_TSEL_BIT   = 5;
  localparam int unsigned AOF_CNT_MSB    = 4;
  localparam int unsigned AOF_CNT_LSB    = 0;
  localparam logic [7:0] AOF_CTL_RST     = 8'h00;
  // buffer_status fields
  localparam int unsigned AOF_TRIG_BIT   = 7;
  localparam logic [5:0] AOF_FULL_CNT    = 6'h20;
  // buffer modes
  typedef enum logic [1:0] {
    AOF_BYPASS  = 2'h0,
    AOF_FILL    = 2'h1,
    AOF_STREAM  = 2'h2,
    AOF_TRIGGER = 2'h3
  } aof_mode_e;
endpackage : aof_pkg

// ---- aof_top.sv ----
// accelerometer output sample buffer with axis and buffer registers
//
// Behaviour
// - axis samples read as two's complement bytes, low first, x/y/z at 0x32..0x37.
// - control bits 7:6 select mode; 00 is bypass, no buffering.
// - mode 01 stores up to 32 entries, then drops until space frees.
// - mode 10 keeps latest 32 samples, overwriting oldest when full.
// - mode 11 keeps history until trigger, then fills and stops.
// - control bit 5 picks which interrupt output triggers: 0 first, 1 second.
// - writing sample count zero sets watermark immediately in every mode.
// - sample count sets watermark level in modes 01/10; ignored in bypass.
// - in triggered mode sample count bounds the pre-trigger history.
// - status bit 7 shows trigger seen, bit 6 reads zero.
// - status bits 5:0 give stored count; samples read via axis registers.
// - any axis data read burst removes one buffer level.
// - buffer holds 32, plus one at output stage gives 33.
// - data-ready, overrun set on events, cleared by axis reads; watermark follows level vs count.
// - while sleeping no samples enter the buffer.
`timescale 1ns/10ps
module aof_top
  import aof_pkg::*;
(
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  // sample source
  input  wire logic                          smp_valid,
  input  wire logic [aof_pkg::AOF_SMP_W-1:0] smp_x,
  input  wire logic [aof_pkg::AOF_SMP_W-1:0] smp_y,
  input  wire logic [aof_pkg::AOF_SMP_W-1:0] smp_z,
  input  wire logic                          sleep_en,
  // trigger sources
  input  wire logic                          irq_out_first,
  input  wire logic                          irq_out_second,
  // register port
  input  wire logic [7:0]                    reg_addr,
  input  wire logic                          reg_wr,
  input  wire logic [7:0]                    reg_wdata,
  input  wire logic                          reg_rd,
  input  wire logic                          reg_rd_last,
  output logic      [7:0]                    reg_rdata_q,
  // event flags
  output logic                               data_ready_q,
  output logic                               watermark_q,
  output logic                               overrun_q
);
  import aof_pkg::*;

  function automatic logic is_axis(input logic [7:0] a);
    is_axis = (a >= AOF_X_LOW_ADDR) && (a <= AOF_Z_HIGH_ADDR);
  endfunction : is_axis

  function automatic logic [7:0] axis_byte(input logic [AOF_ENT_W-1:0] e,
                                           input logic [7:0] a);
    logic [7:0] idx;
    idx = a - AOF_X_LOW_ADDR;
    axis_byte = e[idx[2:0]*8 +: 8];
  endfunction : axis_byte

  logic [7:0]           ctl_q, ctl_d;
  logic [AOF_ENT_W-1:0] mem_q [AOF_DEPTH];
  logic [AOF_PTR_W-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AOF_CNT_W-1:0] cnt_q, cnt_d;
  logic [AOF_ENT_W-1:0] out_q, out_d;
  logic                 out_valid_q, out_valid_d;
  logic                 trig_q, trig_d;
  logic                 touched_q;

  aof_mode_e mode_q;
  wire [4:0] samples = ctl_q[AOF_CNT_MSB:AOF_CNT_LSB];
  wire [AOF_ENT_W-1:0] smp_ent = {smp_z, smp_y, smp_x};
  assign mode_q = aof_mode_e'(ctl_q[AOF_MODE_MSB:AOF_MODE_LSB]);

  // register port decode
  wire ctl_wr  = reg_wr && (reg_addr == AOF_CTL_ADDR);
  wire ax_rd   = reg_rd && is_axis(reg_addr);
  wire rd_done = reg_rd && reg_rd_last && (touched_q || is_axis(reg_addr));
  wire [1:0] new_mode = reg_wdata[AOF_MODE_MSB:AOF_MODE_LSB];
  wire flush   = ctl_wr && (new_mode == AOF_BYPASS);

  // sample admission
  wire bypass   = (mode_q == AOF_BYPASS);
  wire push     = smp_valid && !sleep_en;
  wire push_buf = push && !bypass;
  wire full     = (cnt_q == AOF_FULL_CNT);
  wire pretrig  = (mode_q == AOF_TRIGGER) && !trig_q;
  wire hold     = (mode_q == AOF_FILL) || ((mode_q == AOF_TRIGGER) && trig_q);
  wire no_hist  = pretrig && (samples == 5'h00);
  wire enq      = push_buf && !(full && hold) && !no_hist;
  wire out_free = !out_valid_q || rd_done;
  wire deq      = !bypass && out_free && (cnt_q != '0);
  wire hist_lim = pretrig && ({1'b0, samples} <= cnt_q);
  wire drop_old = enq && !deq && ((full && mode_q == AOF_STREAM) || hist_lim);
  wire ovr_evt  = (push_buf && full && hold) ||
                  (push_buf && full && (mode_q == AOF_STREAM) && !deq) ||
                  (push && bypass && out_valid_q && !rd_done);

  // trigger selection
  wire trig_src = ctl_q[AOF_TSEL_BIT] ? irq_out_second : irq_out_first;
  wire trig_evt = (mode_q == AOF_TRIGGER) && trig_src;

  // pointer and level arithmetic
  always_comb begin
    ctl_d = ctl_wr ? reg_wdata : ctl_q;
    wp_d  = enq ? wp_q + 5'h01 : wp_q;
    rp_d  = (deq || drop_old) ? rp_q + 5'h01 : rp_q;
    cnt_d = cnt_q;
    if (enq && !(deq || drop_old)) begin
      cnt_d = cnt_q + 6'h01;
    end else if (!enq && deq) begin
      cnt_d = cnt_q - 6'h01;
    end
    if (flush) begin
      wp_d  = '0;
      rp_d  = '0;
      cnt_d = '0;
    end
  end

  // output stage holds the one extra sample
  always_comb begin
    out_d       = out_q;
    out_valid_d = out_valid_q && !rd_done;
    if (bypass && push) begin
      out_d       = smp_ent;
      out_valid_d = 1'b1;
    end else if (deq) begin
      out_d       = mem_q[rp_q];
      out_valid_d = 1'b1;
    end
  end

  assign trig_d = (trig_q && !ctl_wr) || trig_evt;

  // read data selection
  wire [7:0] stat_byte = {trig_q, 1'b0, cnt_q + {5'h00, out_valid_q}};
  wire [7:0] rd_mux = is_axis(reg_addr)          ? axis_byte(out_q, reg_addr) :
                      (reg_addr == AOF_CTL_ADDR)  ? ctl_q :
                      (reg_addr == AOF_STAT_ADDR) ? stat_byte : 8'h00;
  wire wm_lvl = (ctl_d[AOF_CNT_MSB:AOF_CNT_LSB] == 5'h00) ||
                ((mode_q != AOF_BYPASS) && (mode_q != AOF_TRIGGER) &&
                 (cnt_d >= {1'b0, ctl_d[AOF_CNT_MSB:AOF_CNT_LSB]}));

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl_q       <= AOF_CTL_RST;
      wp_q        <= '0;
      rp_q        <= '0;
      cnt_q       <= '0;
      out_q       <= '0;
      out_valid_q <= 1'b0;
      trig_q      <= 1'b0;
      touched_q   <= 1'b0;
    end else begin
      ctl_q       <= ctl_d;
      wp_q        <= wp_d;
      rp_q        <= rp_d;
      cnt_q       <= cnt_d;
      out_q       <= out_d;
      out_valid_q <= out_valid_d;
      trig_q      <= trig_d;
      touched_q   <= reg_rd && !reg_rd_last && (touched_q || ax_rd);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (enq) begin
      mem_q[wp_q] <= smp_ent;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_q  <= 8'h00;
      data_ready_q <= 1'b0;
      watermark_q  <= 1'b0;
      overrun_q    <= 1'b0;
    end else begin
      if (reg_rd) begin
        reg_rdata_q <= rd_mux;
      end
      data_ready_q <= out_valid_d && !sleep_en;
      watermark_q  <= wm_lvl;
      overrun_q    <= ovr_evt || (overrun_q && !rd_done);
    end
  end

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  property p_bypass_empty;
    (mode_q == AOF_BYPASS) |-> (cnt_q == '0);
  endproperty
  a_bypass_empty: assert property (p_bypass_empty)
    else $error("buffer holds entries in bypass");

  property p_max_level;
    cnt_q <= AOF_FULL_CNT;
  endproperty
  a_max_level: assert property (p_max_level)
    else $error("buffer level above 32");

  property p_fill_stop;
    (mode_q == AOF_FILL && full && push && !deq && !ctl_wr)
      |=> (cnt_q == AOF_FULL_CNT) && $stable(wp_q) && overrun_q;
  endproperty
  a_fill_stop: assert property (p_fill_stop)
    else $error("fill mode stored past full");

  property p_stream_ovw;
    (mode_q == AOF_STREAM && full && push && !deq && !ctl_wr)
      |=> (cnt_q == AOF_FULL_CNT) && (rp_q == $past(rp_q) + 5'h01);
  endproperty
  a_stream_ovw: assert property (p_stream_ovw)
    else $error("stream mode did not overwrite oldest");

  property p_trig_seen;
    (mode_q == AOF_TRIGGER && (ctl_q[AOF_TSEL_BIT] ? irq_out_second : irq_out_first))
      |=> trig_q;
  endproperty
  a_trig_seen: assert property (p_trig_seen)
    else $error("selected trigger input not recorded");

  property p_trig_sel;
    (!trig_q && !(mode_q == AOF_TRIGGER &&
                  (ctl_q[AOF_TSEL_BIT] ? irq_out_second : irq_out_first))) |=> !trig_q;
  endproperty
  a_trig_sel: assert property (p_trig_sel)
    else $error("unselected trigger input recorded");

  property p_wm_zero;
    (reg_wr && reg_addr == AOF_CTL_ADDR && reg_wdata[4:0] == 5'h00) |=> watermark_q;
  endproperty
  a_wm_zero: assert property (p_wm_zero)
    else $error("zero sample count did not set watermark");

  property p_status_read;
    (reg_rd && reg_addr == AOF_STAT_ADDR)
      |=> (reg_rdata_q[6] == 1'b0) && (reg_rdata_q[AOF_TRIG_BIT] == $past(trig_q));
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status byte wrong");

  property p_pop;
    (rd_done && !bypass && cnt_q == '0 && out_valid_q) |=> !out_valid_q;
  endproperty
  a_pop: assert property (p_pop)
    else $error("axis read did not remove a level");

  property p_sleep;
    (sleep_en && !ctl_wr) |=> (cnt_q <= $past(cnt_q));
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sample stored while asleep");

  property p_overrun;
    ovr_evt |=> overrun_q;
  endproperty
  a_overrun: assert property (p_overrun)
    else $error("overrun not flagged");

  property p_pretrig;
    (pretrig && samples != 5'h00 && cnt_q == {1'b0, samples} && !ctl_wr)
      |=> (cnt_q <= $past(cnt_q));
  endproperty
  a_pretrig: assert property (p_pretrig)
    else $error("history grew past sample count");

  property p_bypass_wm;
    (mode_q == AOF_BYPASS && samples != 5'h00 && !ctl_wr) |=> !watermark_q;
  endproperty
  a_bypass_wm: assert property (p_bypass_wm)
    else $error("sample count acted in bypass");

  property p_wm_full;
    ((mode_q == AOF_FILL || mode_q == AOF_STREAM) && full && !ctl_wr) |=> watermark_q;
  endproperty
  a_wm_full: assert property (p_wm_full)
    else $error("watermark low with full buffer");

  property p_ovr_clear;
    (overrun_q && rd_done && !ovr_evt) |=> !overrun_q;
  endproperty
  a_ovr_clear: assert property (p_ovr_clear)
    else $error("overrun not cleared by axis read");

  property p_trig_hold;
    (trig_q && !ctl_wr) |=> trig_q;
  endproperty
  a_trig_hold: assert property (p_trig_hold)
    else $error("trigger flag lost without control write");

  property p_sleep_ready;
    sleep_en |=> !data_ready_q;
  endproperty
  a_sleep_ready: assert property (p_sleep_ready)
    else $error("data ready raised while asleep");

  c_full:    cover property (mode_q == AOF_FILL && full);
  c_stream:  cover property (drop_old && mode_q == AOF_STREAM);
  c_trigger: cover property (trig_evt ##[1:40] (full && trig_q));
  c_burst:   cover property (ax_rd ##1 ax_rd [*4] ##1 rd_done);
endmodule : aof_top

// ---- aof_top_tb.sv ----
// self-checking bench for the output sample buffer
`timescale 1ns/10ps
module aof_top_tb;
  import aof_pkg::*;
  logic        sys_clk = 1'b0, rst = 1'b1, smp_valid = 1'b0, sleep_en = 1'b0;
  logic        irq_out_first = 1'b0, irq_out_second = 1'b0, rd_d = 1'b0;
  logic [15:0] smp_x = '0, smp_y = '0, smp_z = '0;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata_q;
  logic        reg_wr, reg_rd, reg_rd_last, data_ready_q, watermark_q, overrun_q;
  logic [15:0] exp_q[$];
  logic [47:0] mdl_q[$];
  int          n_errors = 0, total_checks = 0, seed;
  always #5 sys_clk = ~sys_clk;
  aof_top aof_top_inst (.sys_clk, .rst, .smp_valid, .smp_x, .smp_y, .smp_z, .sleep_en,
    .irq_out_first, .irq_out_second, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rd_last,
    .reg_rdata_q, .data_ready_q, .watermark_q, .overrun_q);
  aof_host aof_host_inst (.sys_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rd_last);
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test
  // each read byte against the oldest note, mask in the upper half
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    if (rd_d && exp_q.size() > 0) begin
      chk(reg_rdata_q & exp_q[0][15:8], exp_q[0][7:0]);
      void'(exp_q.pop_front());
    end
  end
  task automatic flags(input logic [2:0] e);
    #1;
    chk({5'h0, data_ready_q, watermark_q, overrun_q}, {5'h0, e});
  endtask : flags
  task automatic rd_exp(input logic [7:0] a, input logic [7:0] m, input logic [7:0] v);
    exp_q.push_back({m, v});
    aof_host_inst.rd(a, 1);
  endtask : rd_exp
  // burst read of the oldest modelled sample, low byte first
  task automatic rd_smp(input logic [7:0] m);
    logic [47:0] s;
    s = (mdl_q.size() > 0) ? mdl_q.pop_front() : '0;
    for (int i = 0; i < 6; i++) exp_q.push_back({m, s[8*i +: 8]});
    aof_host_inst.rd(AOF_X_LOW_ADDR, 6);
  endtask : rd_smp
  task automatic smp(input int n);
    logic [47:0] s;
    repeat (n) begin
      s = 48'({$urandom, $urandom});
      @(posedge sys_clk);
      {smp_z, smp_y, smp_x, smp_valid} <= {s, 1'b1};
      if (!sleep_en) mdl_q.push_back(s);
      @(posedge sys_clk);
      smp_valid <= 1'b0;
    end
    repeat (2) @(posedge sys_clk);
  endtask : smp
  initial begin
    #200us;
    n_errors++;
    stop_test();
  end
  initial begin
    seed = $urandom(32'h19ae);
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    flags(3'b010);
    rd_exp(AOF_STAT_ADDR, 8'hff, 8'h00);
    rd_exp(AOF_CTL_ADDR, 8'hff, AOF_CTL_RST);
    rd_exp(8'h3a, 8'hff, 8'h00);
    aof_host_inst.wr(AOF_STAT_ADDR, 8'hff);
    rd_exp(AOF_STAT_ADDR, 8'hff, 8'h00);
    aof_host_inst.wr(AOF_CTL_ADDR, 8'h44);
    smp(3);
    flags(3'b100);
    smp(2);
    flags(3'b110);
    smp(28);
    rd_exp(AOF_STAT_ADDR, 8'hff, 8'h21);
    smp(1);
    void'(mdl_q.pop_back()); // dropped when full
    flags(3'b111);
    rd_exp(AOF_STAT_ADDR, 8'hff, 8'h21);
    rd_smp(8'hff);
    repeat (3) @(posedge sys_clk);
    flags(3'b110);
    rd_exp(AOF_STAT_ADDR, 8'hff, 8'h20);
    repeat (2) rd_smp(8'hff);
    aof_host_inst.wr(AOF_CTL_ADDR, 8'h84);
    smp(40);
    rd_exp(AOF_STAT_ADDR, 8'hff, 8'h21);
    flags(3'b111);
    while (mdl_q.size() > 33) mdl_q.delete(1); // overwritten in the buffer
    repeat (2) rd_smp(8'hff); // output stage, then oldest survivor
    aof_host_inst.wr(AOF_CTL_ADDR, 8'h00);
    aof_host_inst.wr(AOF_CTL_ADDR, 8'he4); // nonzero count
    smp(10);
    irq_out_first <= 1'b1;
    smp(1);
    rd_exp(AOF_STAT_ADDR, 8'hff, 8'h05);
    irq_out_second <= 1'b1;
    smp(1);
    rd_exp(AOF_STAT_ADDR, 8'hff, 8'h86);
    smp(40);
    rd_exp(AOF_STAT_ADDR, 8'hff, 8'ha1);
    aof_host_inst.wr(AOF_CTL_ADDR, 8'h40);
    #1 chk({7'h0, watermark_q}, 8'h01);
    aof_host_inst.wr(AOF_CTL_ADDR, 8'h04); // bypass, count without effect
    while (mdl_q.size() > 1) void'(mdl_q.pop_back());
    rd_smp(8'hff); // flush leaves the output stage
    sleep_en <= 1'b1;
    smp(1);
    flags(3'b000);
    sleep_en <= 1'b0;
    smp(1);
    flags(3'b100);
    rd_smp(8'hff);
    repeat (3) @(posedge sys_clk);
    stop_test();
  end
endmodule : aof_top_tb
